// >>> verilog/rld_rotate_left.sv
// rld_rotate_left: one-cycle rotate-left execution slice of the 8-bit core
// assumes decoder supplies operand byte and current flags on the core clock
// and a reset whose release is already synchronised to i_mclk
`timescale 1ns/1ns
`default_nettype none

module rld_rotate_left (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // request from decoder
  input wire rld_pkg::rld_req_t i_req,
  // result to writeback
  output rld_pkg::rld_res_t o_res
);

  // ---------------------------------------------------------------
  // operand decode
  // ---------------------------------------------------------------
  // bits that move up one place in every variant
  logic [rld_pkg::RLD_MSB-1:0] low_bits;
  // bit that leaves at the top: wraps to bit 0, or becomes the new carry
  logic top_bit;
  // circular result: nothing enters from outside the byte
  logic [rld_pkg::RLD_DW-1:0] rot_plain;
  // eight-bit result of the nine-bit rotate: the old carry fills bit 0
  logic [rld_pkg::RLD_DW-1:0] rot_carry;

  assign low_bits = i_req.operand[rld_pkg::RLD_MSB-1:0];
  assign top_bit = i_req.operand[rld_pkg::RLD_MSB];
  assign rot_plain = {low_bits, top_bit};
  assign rot_carry = {low_bits, i_req.carry};

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  // the instruction settles in one cycle: the registered result is ready
  // for writeback at the edge after the request is taken. flags are echoed
  // every cycle so writeback never needs to qualify them; only the two
  // strobes say whether and where to write.
  rld_pkg::rld_res_t res_r;
  rld_pkg::rld_res_t res_nxt;

  always_comb begin
    res_nxt = res_r;
    // strobes default low, so each known request gives exactly one write pulse
    res_nxt.mem_we = 1'b0;
    res_nxt.acc_we = 1'b0;
    // flags pass through by default so unselected flags never move
    res_nxt.carry = i_req.carry;
    res_nxt.zero = i_req.zero;
    res_nxt.ovf = i_req.ovf;
    res_nxt.aux = i_req.aux;
    if (i_req.valid) begin
      case (i_req.op)
        rld_pkg::RLD_OP_ROTATE_MEM_LEFT: begin
          // memory gets the circular result, no flag moves
          res_nxt.data = rot_plain;
          res_nxt.mem_we = 1'b1;
        end
        rld_pkg::RLD_OP_ROTATE_MEM_LEFT_TO_ACC: begin
          // accumulator gets the circular result, memory is not strobed
          res_nxt.data = rot_plain;
          res_nxt.acc_we = 1'b1;
        end
        rld_pkg::RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY: begin
          // top bit leaves as the new carry; old carry enters bit 0
          res_nxt.data = rot_carry;
          res_nxt.carry = top_bit;
          res_nxt.mem_we = 1'b1;
        end
        rld_pkg::RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY_TO_ACC: begin
          // same nine-bit rotate, result to the accumulator only
          res_nxt.data = rot_carry;
          res_nxt.carry = top_bit;
          res_nxt.acc_we = 1'b1;
        end
        default: begin
          // unknown code: no write, flags echoed unchanged
          // holding data keeps a stray code from disturbing the writeback value
          res_nxt.data = res_r.data;
        end
      endcase
    end
  end

  // reset clears the strobes so nothing is written before the first request
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      res_r <= '{mem_we: 1'b0, acc_we: 1'b0, data: rld_pkg::RLD_DATA_RST,
                 carry: rld_pkg::RLD_FLAG_RST, zero: rld_pkg::RLD_FLAG_RST,
                 ovf: rld_pkg::RLD_FLAG_RST, aux: rld_pkg::RLD_FLAG_RST};
    end else begin
      res_r <= res_nxt;
    end
  end

  assign o_res = res_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // each check compares with the request input one edge earlier
  a_plain_mem_rot: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT |=> o_res.mem_we && !o_res.acc_we
    && o_res.data == {$past(i_req.operand[6:0]), $past(i_req.operand[7])}
    && o_res.carry == $past(i_req.carry))
    else $error("plain memory rotate wrong");

  a_plain_acc_rot: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT_TO_ACC |=> o_res.acc_we
    && !o_res.mem_we && o_res.data == {$past(i_req.operand[6:0]), $past(i_req.operand[7])}
    && o_res.carry == $past(i_req.carry))
    else $error("plain accumulator rotate wrong");

  a_carry_mem_rot: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY |=> o_res.mem_we
    && !o_res.acc_we && o_res.data == {$past(i_req.operand[6:0]), $past(i_req.carry)}
    && o_res.carry == $past(i_req.operand[7]))
    else $error("carry memory rotate wrong");

  a_carry_acc_rot: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY_TO_ACC |=> o_res.acc_we
    && !o_res.mem_we && o_res.data == {$past(i_req.operand[6:0]), $past(i_req.carry)}
    && o_res.carry == $past(i_req.operand[7]))
    else $error("carry accumulator rotate wrong");

  a_other_flags_kept: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid |=> o_res.zero == $past(i_req.zero) && o_res.ovf == $past(i_req.ovf)
    && o_res.aux == $past(i_req.aux))
    else $error("non-carry flag changed");

  a_idle_no_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_req.valid |=> !o_res.mem_we && !o_res.acc_we)
    else $error("write without request");

  // ---------------------------------------------------------------
  // refused and idle cycles
  // ---------------------------------------------------------------
  // a code that is not one-hot must leave memory, accumulator and data alone
  a_bad_op_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && !$onehot(i_req.op) |=> !o_res.mem_we && !o_res.acc_we
    && o_res.data == $past(o_res.data) && o_res.carry == $past(i_req.carry))
    else $error("refused code changed state");

  a_idle_data_held: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_req.valid |=> o_res.data == $past(o_res.data))
    else $error("result moved while idle");

  // writeback may take the flags unconditionally, so they echo every cycle
  a_idle_flags_echo: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_req.valid |=> o_res.carry == $past(i_req.carry) && o_res.zero == $past(i_req.zero)
    && o_res.ovf == $past(i_req.ovf) && o_res.aux == $past(i_req.aux))
    else $error("flag not echoed while idle");

  // ---------------------------------------------------------------
  // behaviour shared by two or more of the four variants
  // ---------------------------------------------------------------
  // plain variants touch no flag at all, carry included
  a_plain_flags_kept: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && (i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT
    || i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT_TO_ACC)
    |=> o_res.carry == $past(i_req.carry) && o_res.zero == $past(i_req.zero)
    && o_res.ovf == $past(i_req.ovf) && o_res.aux == $past(i_req.aux))
    else $error("plain rotate moved a flag");

  // every variant moves bits 0 to 6 up one place
  a_bits_move_up: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && $onehot(i_req.op) |=> o_res.data[7:1] == $past(i_req.operand[6:0]))
    else $error("low bits not moved up one place");

  // accumulator forms must never strobe the memory byte
  a_acc_keeps_mem: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && (i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT_TO_ACC
    || i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY_TO_ACC) |=> !o_res.mem_we)
    else $error("accumulator form strobed memory");

  // ---------------------------------------------------------------
  // write strobes and reset
  // ---------------------------------------------------------------
  // one request writes one place: memory or accumulator, never both
  a_one_target: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !(o_res.mem_we && o_res.acc_we))
    else $error("both write strobes high");

  // a strobe is only ever the answer to a known request one edge before
  a_write_has_req: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_res.mem_we || o_res.acc_we |-> $past(i_req.valid) && $onehot($past(i_req.op)))
    else $error("write strobe without a known request");

  // every known request writes exactly one place
  a_known_op_writes: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && $onehot(i_req.op) |=> o_res.mem_we != o_res.acc_we)
    else $error("known request did not write once");

  // the first edge after release must still show the cleared result
  a_reset_clears: assert property (@(posedge i_mclk)
    $rose(i_rst_b) |-> !o_res.mem_we && !o_res.acc_we
    && o_res.data == rld_pkg::RLD_DATA_RST && o_res.carry == rld_pkg::RLD_FLAG_RST)
    else $error("result not cleared by reset");

  // ---------------------------------------------------------------
  // scenario reach
  // ---------------------------------------------------------------
  // each instruction and a refused code should be seen at least once
  c_plain_mem: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT);

  c_plain_acc: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT_TO_ACC);

  c_carry_mem: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY);

  c_carry_acc: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && i_req.op == rld_pkg::RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY_TO_ACC);

  c_bad_op: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_req.valid && !$onehot(i_req.op));

endmodule // rld_rotate_left

`default_nettype wire

// >>> verilog/rld_pkg.sv
// rld_pkg: constants and carrier types for the rotate-left datapath slice
// assumes a single core clock domain; included by package name only
package rld_pkg;

  // ---------------------------------------------------------------
  // operation selection
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    RLD_OP_ROTATE_MEM_LEFT                = 4'h1,
    RLD_OP_ROTATE_MEM_LEFT_TO_ACC         = 4'h2,
    RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY      = 4'h4,
    RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY_TO_ACC = 4'h8
  } rld_op_t;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int RLD_DW = 8;
  localparam int RLD_MSB = 7;
  localparam logic [7:0] RLD_DATA_RST = 8'h00;
  localparam logic RLD_FLAG_RST = 1'b0;
  localparam int RLD_LATENCY = 1;

  // request from the decoder: operand byte plus current flag state
  typedef struct packed {
    logic valid;
    rld_op_t op;
    logic [7:0] operand;
    logic carry;
    logic zero;
    logic ovf;
    logic aux;
  } rld_req_t;

  // result for the writeback path
  typedef struct packed {
    logic mem_we;
    logic acc_we;
    logic [7:0] data;
    logic carry;
    logic zero;
    logic ovf;
    logic aux;
  } rld_res_t;

endpackage

// >>> sim/rld_core_model.sv
// rld_core_model: core writeback side, one memory byte and the accumulator
// assumes the slice result arrives on the core clock
`timescale 1ns/1ns
`default_nettype none
module rld_core_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // writeback from the slice
  input wire rld_pkg::rld_res_t i_res,
  // stored state
  output logic [7:0] o_mem,
  output logic [7:0] o_acc
);
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem <= 8'h00;
      o_acc <= 8'h00;
    end else begin
      if (i_res.mem_we) o_mem <= i_res.data;
      if (i_res.acc_we) o_acc <= i_res.data;
    end
  end
endmodule // rld_core_model
`default_nettype wire

// >>> sim/rld_rotate_left_tb_top.sv
// rld_rotate_left_tb_top: directed bench for the rotate-left slice
// assumes the answer comes exactly one cycle after a taken request
`timescale 1ns/1ns
`default_nettype none
module rld_rotate_left_tb_top;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  rld_pkg::rld_req_t req = '0;
  rld_pkg::rld_res_t res;
  logic [7:0] mem, acc;
  logic [7:0] v [4] = '{8'h81, 8'h7e, 8'h00, 8'hff};
  int n_fail = 0;
  int checks_done = 0;
  rld_rotate_left u_rld_rotate_left (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(req), .o_res(res));
  rld_core_model u_rld_core_model (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_res(res), .o_mem(mem),
    .o_acc(acc));
  initial forever #5 i_mclk = ~i_mclk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // zero/ovf/aux fed as 1,0,1 so a flag that moves is seen
  task automatic run(input rld_pkg::rld_op_t op, input logic [7:0] d, input logic c);
    @(posedge i_mclk);
    req <= '{1'b1, op, d, c, 1'b1, 1'b0, 1'b1};
    @(posedge i_mclk);
    req.valid <= 1'b0;
    #1;
  endtask
  task automatic t_plain();
    foreach (v[i]) begin
      run(rld_pkg::RLD_OP_ROTATE_MEM_LEFT, v[i], 1'b1);
      chk({2'b0, res}, {4'b0010, v[i][6:0], v[i][7], 4'b1101});
      run(rld_pkg::RLD_OP_ROTATE_MEM_LEFT_TO_ACC, ~v[i], 1'b0);
      chk({2'b0, res}, {4'b0001, ~v[i][6:0], ~v[i][7], 4'b0101});
      @(posedge i_mclk);
      #1;
      chk({mem, acc}, {v[i][6:0], v[i][7], ~v[i][6:0], ~v[i][7]});
    end
  endtask
  task automatic t_carry();
    for (int c = 0; c < 2; c++) begin
      foreach (v[i]) begin
        run(rld_pkg::RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY, v[i], c[0]);
        chk({2'b0, res}, {4'b0010, v[i][6:0], c[0], v[i][7], 3'b101});
        run(rld_pkg::RLD_OP_ROTATE_MEM_LEFT_VIA_CARRY_TO_ACC, v[i], ~c[0]);
        chk({2'b0, res}, {4'b0001, v[i][6:0], ~c[0], v[i][7], 3'b101});
        @(posedge i_mclk);
        #1;
        chk({mem, acc}, {v[i][6:0], c[0], v[i][6:0], ~c[0]});
      end
    end
  endtask
  // a refused code writes nothing, holds the last result (8'hfe) and echoes flags
  task automatic t_refused();
    run(rld_pkg::rld_op_t'(4'h3), 8'h5a, 1'b0);
    chk({2'b0, res}, 16'h0fe5);
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    // outputs are cleared from the first edge in reset onward
    chk({2'b0, res}, 16'h0000);
    i_rst_b <= 1'b1;
    t_plain();
    t_carry();
    t_refused();
    end_of_test();
  end
  // about 25 requests of 2 or 3 cycles each; allow far more than that
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
endmodule // rld_rotate_left_tb_top
`default_nettype wire
